/* File: rtl/msar_regs.sv */
// Purpose: Pin status, conversion update and alarm registers with serial slave
// Assumes: Measurement, threshold and config inputs come from logic on clk
// Notes: Only offsets 6Eh to 70h are mapped; other offsets read zero
`timescale 1ns/10ps
module msar_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic tx_disable_pin,
  input wire logic fault_input_pin,
  input wire logic rate_select_pin,
  input wire logic power_on_analog_trip,
  input wire logic fault_input_invert,
  input wire logic fault_output_state,
  input wire logic signal_loss_state,
  input wire logic legacy_compat_mode,
  input wire logic meas_done,
  input wire logic [2:0] meas_channel,
  input wire logic [15:0] meas_value,
  input wire logic [15:0] meas_thr_hi,
  input wire logic [15:0] meas_thr_lo,
  input wire logic rx_power_range,
  output logic tx_disabled,
  output logic not_ready_flag,
  output logic [1:0] monitor_impedance_bits,
  output logic monitor_impedance_write
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic scl_s, sda_s, txd_s, fault_s, rate_s, trip_s;

  msar_sync #(
    .W(6),
    .RST(6'h03)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d({power_on_analog_trip, rate_select_pin, fault_input_pin,
        tx_disable_pin, sda_pin_in, scl_pin}),
    .q(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign txd_s = pins_s[2];
  assign fault_s = pins_s[3];
  assign rate_s = pins_s[4];
  assign trip_s = pins_s[5];

  // ----------------------------------------------------------------
  // Serial bus edge and condition detection
  // ----------------------------------------------------------------
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------
  msar_pkg::msar_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic ack_phase_r;
  logic rd_mode_r;
  logic oe_r;
  logic wr_pulse_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= msar_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_phase_r <= 1'b0;
      rd_mode_r <= 1'b0;
      oe_r <= 1'b0;
      wr_pulse_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_pulse_r <= 1'b0;
      if (bus_start) begin
        state_r <= msar_pkg::ST_DEV;
        bit_cnt_r <= 4'h0;
        ack_phase_r <= 1'b0;
        oe_r <= 1'b0;
      end else if (bus_stop) begin
        state_r <= msar_pkg::ST_IDLE;
        oe_r <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          msar_pkg::ST_DEV, msar_pkg::ST_PTR, msar_pkg::ST_WR: begin
            if (!ack_phase_r && bit_cnt_r < msar_pkg::BYTE_BITS) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
          msar_pkg::ST_RD: begin
            if (ack_phase_r) begin
              // Master answer: low asks for the next byte, high ends the read
              if (sda_s) begin
                state_r <= msar_pkg::ST_IDLE;
              end else begin
                tx_r <= rd_data;
                bit_cnt_r <= 4'h0;
                ack_phase_r <= 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          msar_pkg::ST_DEV: begin
            if (ack_phase_r) begin
              ack_phase_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              if (rd_mode_r) begin
                state_r <= msar_pkg::ST_RD;
                oe_r <= ~rd_data[7];
                tx_r <= {rd_data[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
              end else begin
                state_r <= msar_pkg::ST_PTR;
                oe_r <= 1'b0;
              end
            end else if (bit_cnt_r == msar_pkg::BYTE_BITS) begin
              if (shift_r[7:1] == msar_pkg::DEV_ADDR) begin
                ack_phase_r <= 1'b1;
                rd_mode_r <= shift_r[0];
                oe_r <= 1'b1;
              end else begin
                state_r <= msar_pkg::ST_IDLE;
              end
            end
          end
          msar_pkg::ST_PTR, msar_pkg::ST_WR: begin
            if (ack_phase_r) begin
              ack_phase_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              oe_r <= 1'b0;
              state_r <= msar_pkg::ST_WR;
              if (state_r == msar_pkg::ST_WR) begin
                ptr_r <= ptr_r + 8'h01;
              end
            end else if (bit_cnt_r == msar_pkg::BYTE_BITS) begin
              ack_phase_r <= 1'b1;
              oe_r <= 1'b1;
              if (state_r == msar_pkg::ST_PTR) begin
                ptr_r <= shift_r;
              end else begin
                wr_pulse_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= shift_r;
              end
            end
          end
          msar_pkg::ST_RD: begin
            if (!ack_phase_r) begin
              if (bit_cnt_r < msar_pkg::BYTE_BITS) begin
                oe_r <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end else begin
                // Release for the master's answer and step to the next byte
                oe_r <= 1'b0;
                ack_phase_r <= 1'b1;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe = oe_r;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_status, wr_update;

  assign wr_status = wr_pulse_r && (wr_addr_r == msar_pkg::PIN_STATUS_OFS);
  assign wr_update = wr_pulse_r && (wr_addr_r == msar_pkg::CONV_UPDATE_OFS);

  // ----------------------------------------------------------------
  // Pin status register
  // ----------------------------------------------------------------
  logic soft_tx_disable_r;
  logic [7:0] pin_status;

  // Only bit 6 takes the write; the rest of the byte is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      soft_tx_disable_r <= msar_pkg::SOFT_TXD_RST;
    end else if (wr_status) begin
      soft_tx_disable_r <= wr_data_r[msar_pkg::PS_SOFT_TXD];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_disabled <= 1'b0;
      not_ready_flag <= 1'b1;
    end else begin
      tx_disabled <= txd_s | soft_tx_disable_r;
      not_ready_flag <= ~trip_s;
    end
  end

  always_comb begin
    pin_status = 8'h00;
    pin_status[msar_pkg::PS_TXD_PIN] = txd_s;
    pin_status[msar_pkg::PS_SOFT_TXD] = soft_tx_disable_r;
    pin_status[msar_pkg::PS_FAULT_IN] = fault_s ^ fault_input_invert;
    pin_status[msar_pkg::PS_RATE_SEL] = rate_s;
    pin_status[msar_pkg::PS_FAULT_OUT] = fault_output_state;
    pin_status[msar_pkg::PS_SIG_LOSS] = signal_loss_state;
    pin_status[msar_pkg::PS_NOT_READY] = ~trip_s;
  end

  // ----------------------------------------------------------------
  // Conversion update register
  // ----------------------------------------------------------------
  logic [4:0] rdy_r;
  logic [4:0] rdy_set;
  logic rx_range_r;
  logic [1:0] power_level_r;
  logic legacy_q;
  logic [7:0] conv_update;

  always_comb begin
    rdy_set = 5'h00;
    if (meas_done && meas_channel <= msar_pkg::CH_RXPWR) begin
      rdy_set[3'h4 - meas_channel] = 1'b1;
    end
  end

  // Host may only clear a flag; a completion in the same cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      rdy_r <= msar_pkg::CONV_UPDATE_RST[msar_pkg::UPD_RDY_MSB:msar_pkg::UPD_RDY_LSB];
    end else if (wr_update) begin
      rdy_r <= (rdy_r & wr_data_r[msar_pkg::UPD_RDY_MSB:msar_pkg::UPD_RDY_LSB])
               | rdy_set;
    end else begin
      rdy_r <= rdy_r | rdy_set;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_range_r <= msar_pkg::CONV_UPDATE_RST[msar_pkg::UPD_RX_RANGE];
    end else if (meas_done && meas_channel == msar_pkg::CH_RXPWR) begin
      rx_range_r <= rx_power_range;
    end else if (wr_update) begin
      rx_range_r <= wr_data_r[msar_pkg::UPD_RX_RANGE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      power_level_r <= msar_pkg::CONV_UPDATE_RST[msar_pkg::UPD_POW_MSB:msar_pkg::UPD_POW_LSB];
    end else if (wr_update) begin
      power_level_r <= wr_data_r[msar_pkg::UPD_POW_MSB:msar_pkg::UPD_POW_LSB];
    end
  end

  // Push to the driver on a write outside legacy mode, or when legacy mode is left
  always_ff @(posedge clk) begin
    if (srst) begin
      legacy_q <= 1'b1;
      monitor_impedance_bits <= 2'h0;
      monitor_impedance_write <= 1'b0;
    end else begin
      legacy_q <= legacy_compat_mode;
      monitor_impedance_write <= 1'b0;
      if (!legacy_compat_mode && (wr_update || legacy_q)) begin
        monitor_impedance_bits <= wr_update ?
          wr_data_r[msar_pkg::UPD_POW_MSB:msar_pkg::UPD_POW_LSB] : power_level_r;
        monitor_impedance_write <= 1'b1;
      end
    end
  end

  assign conv_update = {rdy_r, rx_range_r, power_level_r};

  // ----------------------------------------------------------------
  // Alarm register
  // ----------------------------------------------------------------
  logic [7:0] alarms_r;
  logic [7:0] alarms_nxt;
  logic cmp_above, cmp_below;

  msar_cmp u_cmp (
    .channel(meas_channel),
    .value(meas_value),
    .thr_hi(meas_thr_hi),
    .thr_lo(meas_thr_lo),
    .above(cmp_above),
    .below(cmp_below)
  );

  always_comb begin
    alarms_nxt = alarms_r;
    if (meas_done && meas_channel < msar_pkg::CH_RXPWR) begin
      alarms_nxt[3'h7 - {meas_channel[1:0], 1'b0}] = cmp_above;
      alarms_nxt[3'h6 - {meas_channel[1:0], 1'b0}] = cmp_below;
    end
    // Low supply overrides any VCC low-alarm measurement result
    if (!trip_s) begin
      alarms_nxt[msar_pkg::ALM_VCC_LO] = 1'b1;
    end
  end

  // No write path: the host cannot touch alarms
  always_ff @(posedge clk) begin
    if (srst) begin
      alarms_r <= msar_pkg::MEAS_ALARMS_RST;
    end else begin
      alarms_r <= alarms_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (ptr_r)
      msar_pkg::PIN_STATUS_OFS: rd_data = pin_status;
      msar_pkg::CONV_UPDATE_OFS: rd_data = conv_update;
      msar_pkg::MEAS_ALARMS_OFS: rd_data = alarms_r;
      default: rd_data = msar_pkg::UNMAPPED_READ;
    endcase
  end

endmodule // msar_regs

/* File: rtl/msar_pkg.sv */
// Purpose: Shared constants for the monitor status and alarm register group
// Assumes: Byte-wide registers reached over the two-wire serial bus
// Notes: Every offset lives here, with the named field positions and the mapped registers' reset values
package msar_pkg;

  // ----------------------------------------------------------------
  // Serial bus
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h51;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_PTR,
    ST_WR,
    ST_RD
  } msar_state_e;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_STATUS_OFS = 8'h6E;
  localparam logic [7:0] CONV_UPDATE_OFS = 8'h6F;
  localparam logic [7:0] MEAS_ALARMS_OFS = 8'h70;
  localparam logic [7:0] CONV_UPDATE_RST = 8'h00;
  localparam logic [7:0] MEAS_ALARMS_RST = 8'h10;
  localparam logic SOFT_TXD_RST = 1'b0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PS_TXD_PIN = 7;
  localparam int PS_SOFT_TXD = 6;
  localparam int PS_FAULT_IN = 5;
  localparam int PS_RATE_SEL = 4;
  localparam int PS_FAULT_OUT = 2;
  localparam int PS_SIG_LOSS = 1;
  localparam int PS_NOT_READY = 0;
  localparam int UPD_RDY_MSB = 7;
  localparam int UPD_RDY_LSB = 3;
  localparam int UPD_RX_RANGE = 2;
  localparam int UPD_POW_MSB = 1;
  localparam int UPD_POW_LSB = 0;
  localparam int ALM_VCC_LO = 4;
  localparam int LDD_IMP_MSB = 2;
  localparam int LDD_IMP_LSB = 1;

  // ----------------------------------------------------------------
  // Measurement channels
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_VCC = 3'h1;
  localparam logic [2:0] CH_BIAS = 3'h2;
  localparam logic [2:0] CH_TXPWR = 3'h3;
  localparam logic [2:0] CH_RXPWR = 3'h4;

  // Greater-than with optional two's complement view
  function automatic logic cmp_gt(input logic [15:0] a, input logic [15:0] b,
                                  input logic signed_cmp);
    if (signed_cmp) begin
      cmp_gt = $signed(a) > $signed(b);
    end else begin
      cmp_gt = a > b;
    end
  endfunction

endpackage

/* File: rtl/msar_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: Reset values chosen per bit so idle bus lines read high
`timescale 1ns/10ps
module msar_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // First stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // msar_sync

/* File: rtl/msar_cmp.sv */
// Purpose: Compare one finished measurement with its thresholds
// Assumes: Thresholds arrive alongside the measurement
// Notes: Temperature is signed, every other channel unsigned
`timescale 1ns/10ps
module msar_cmp (
  input wire logic [2:0] channel,
  input wire logic [15:0] value,
  input wire logic [15:0] thr_hi,
  input wire logic [15:0] thr_lo,
  output logic above,
  output logic below
);

  logic is_signed;

  // ----------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------
  assign is_signed = (channel == msar_pkg::CH_TEMP);
  assign above = msar_pkg::cmp_gt(value, thr_hi, is_signed);
  assign below = msar_pkg::cmp_gt(thr_lo, value, is_signed);

endmodule // msar_cmp

/* File: bench/msar_host.sv */
// Purpose: Host model that drives the two-wire management bus
// Assumes: SDA is open drain with a pull-up; the host alone drives SCL
// Notes: Phases of 8 clk stay well above the 4-cycle minimum
`timescale 1ns/10ps
module msar_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // SDA moves 2 clk after SCL falls, so a data change never looks like a start or stop
  task automatic bit_x(input logic d, output logic s);
    wait_clk(2);
    sda_low = ~d;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(8);
    s = sda_line;
    scl = 1'b0;
  endtask

  task automatic start();
    wait_clk(2);
    sda_low = 1'b0;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(8);
    sda_low = 1'b1;
    wait_clk(8);
    scl = 1'b0;
  endtask

  // Ends with SCL high and SDA released, so both lines stand still between frames
  task automatic stop();
    wait_clk(2);
    sda_low = 1'b1;
    wait_clk(8);
    scl = 1'b1;
    wait_clk(8);
    sda_low = 1'b0;
    wait_clk(8);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, b[i]);
    end
    bit_x(last, s);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start();
    send_byte({msar_pkg::DEV_ADDR, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start();
    send_byte({msar_pkg::DEV_ADDR, 1'b0}, a);
    send_byte(ofs, a);
    start();
    send_byte({msar_pkg::DEV_ADDR, 1'b1}, a);
    recv_byte(1'b1, d);
    stop();
  endtask
endmodule // msar_host

/* File: bench/msar_regs_properties.sv */
// Purpose: Port-level checks for the status and alarm register group
// Assumes: Pin levels reach the outputs within a few clk of synchronising
// Notes: Six-cycle windows leave room for the two-flop synchronisers
`timescale 1ns/10ps
module msar_regs_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic tx_disable_pin,
  input wire logic power_on_analog_trip,
  input wire logic legacy_compat_mode,
  input wire logic tx_disabled,
  input wire logic not_ready_flag,
  input wire logic [1:0] monitor_impedance_bits,
  input wire logic monitor_impedance_write
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ready_low_a: assert property (power_on_analog_trip [*6] |-> !not_ready_flag)
    else $error("ready flag high with supply above trip");
  ready_high_a: assert property (!power_on_analog_trip [*6] |-> not_ready_flag)
    else $error("ready flag low with supply below trip");
  txd_pin_a: assert property (tx_disable_pin [*6] |-> tx_disabled)
    else $error("transmitter enabled while disable pin high");
  imp_legacy_a: assert property (monitor_impedance_write |-> !$past(legacy_compat_mode))
    else $error("impedance pushed in legacy mode");
  imp_pulse_a: assert property (monitor_impedance_write |=> !monitor_impedance_write)
    else $error("impedance write longer than one cycle");
  imp_change_a: assert property ($changed(monitor_impedance_bits) |-> monitor_impedance_write)
    else $error("impedance bits changed without a write pulse");
endmodule // msar_regs_properties

bind msar_regs msar_regs_properties u_props (
  .clk(clk),
  .srst(srst),
  .tx_disable_pin(tx_disable_pin),
  .power_on_analog_trip(power_on_analog_trip),
  .legacy_compat_mode(legacy_compat_mode),
  .tx_disabled(tx_disabled),
  .not_ready_flag(not_ready_flag),
  .monitor_impedance_bits(monitor_impedance_bits),
  .monitor_impedance_write(monitor_impedance_write)
);

/* File: bench/monitor_status_alarm_regs_tb.sv */
// Purpose: Self-checking bench for the status and alarm register group
// Assumes: Host model reaches the registers over the serial bus
// Notes: Expected values are fixed constants or entries of the te table, except the push count baseline taken from imp_count
`timescale 1ns/10ps
module monitor_status_alarm_regs_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scl, sda_low, sda_oe, sda_out, sda_line;
  logic txd = 1'b0, flt = 1'b0, rate = 1'b0, trip = 1'b0, inv = 1'b0;
  logic fout = 1'b0, sig_loss = 1'b0, legacy = 1'b0, done = 1'b0, rng = 1'b0;
  logic [2:0] ch = 3'h0;
  logic [15:0] val = 16'h0000, thi = 16'h0000, tlo = 16'h0000;
  logic tx_dis, nrdy, imp_wr, ack;
  logic [1:0] imp, imp_last;
  logic [7:0] rd;
  int num_errors = 0, total_checks = 0, cycles = 0, imp_count = 0, n;
  logic [2:0] tc [8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [15:0] tv [8] = '{16'hFFFF, 16'h0001, 16'h8000, 16'h0100, 16'h0101, 16'h0000,
                          16'hFFFF, 16'h0000};
  logic [15:0] th [8] = '{16'h0000, 16'h0000, 16'h7FFF, 16'h0100, 16'h0100, 16'hFFFF,
                          16'h7FFF, 16'h0000};
  logic [15:0] tl [8] = '{16'h8000, 16'h8000, 16'hFFFF, 16'h0100, 16'h0000, 16'h0001,
                          16'h0000, 16'hFFFF};
  logic [7:0] te [8] = '{8'h10, 8'h90, 8'h50, 8'h40, 8'h60, 8'h64, 8'h66, 8'h66};

  // Open-drain wire: low if either party pulls, pull-up otherwise
  // Device pulls only when its enable is up and its driven level is low
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  msar_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  msar_regs dut (
    .clk(clk), .srst(srst), .scl_pin(scl), .sda_pin_in(sda_line), .sda_pin_out(sda_out),
    .sda_pin_oe(sda_oe), .tx_disable_pin(txd), .fault_input_pin(flt),
    .rate_select_pin(rate), .power_on_analog_trip(trip), .fault_input_invert(inv),
    .fault_output_state(fout), .signal_loss_state(sig_loss), .legacy_compat_mode(legacy),
    .meas_done(done), .meas_channel(ch), .meas_value(val), .meas_thr_hi(thi),
    .meas_thr_lo(tlo), .rx_power_range(rng), .tx_disabled(tx_dis), .not_ready_flag(nrdy),
    .monitor_impedance_bits(imp), .monitor_impedance_write(imp_wr)
  );

  always #2.5 clk = ~clk;

  // Records every push to the laser driver; also cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (imp_wr === 1'b1) begin
      imp_count++;
      imp_last <= imp;
    end
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp, input string what);
    u_host.rd(ofs, rd);
    check(what, exp, rd);
  endtask

  task automatic meas(input logic [2:0] c, input logic [15:0] v, h, l);
    @(posedge clk);
    #1;
    done = 1'b1;
    ch = c;
    val = v;
    thi = h;
    tlo = l;
    @(posedge clk);
    #1;
    done = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    u_host.wait_clk(10);
    rchk(8'h70, 8'h10, "alarms reset");
    rchk(8'h6F, 8'h00, "update reset");
    rchk(8'h6E, 8'h01, "status low supply");
    check("not ready", 8'h01, {7'h00, nrdy});
    {txd, flt, rate, trip, inv, fout, sig_loss} = 7'h7F;
    rchk(8'h6E, 8'h96, "status inverted");
    check("tx disabled pin", 8'h01, {7'h00, tx_dis});
    inv = 1'b0;
    rchk(8'h6E, 8'hB6, "status plain");
    {txd, flt, rate, fout, sig_loss} = 5'h00;
    u_host.wr(8'h6E, 8'hFF, ack);
    check("write ack", 8'h01, {7'h00, ack});
    rchk(8'h6E, 8'h40, "status soft");
    check("tx disabled soft", 8'h01, {7'h00, tx_dis});
    u_host.wr(8'h6E, 8'h00, ack);
    check("tx enabled", 8'h00, {7'h00, tx_dis});
    u_host.wr(8'h70, 8'hFF, ack);
    rchk(8'h70, 8'h10, "alarms after write");
    rng = 1'b1;
    for (int i = 0; i < 8; i++) begin
      meas(tc[i], tv[i], th[i], tl[i]);
      rchk(8'h70, te[i], "alarms");
    end
    rchk(8'h6F, 8'hFC, "update flags");
    u_host.wr(8'h6F, 8'h00, ack);
    rchk(8'h6F, 8'h00, "update cleared");
    meas(3'h2, 16'h0000, 16'hFFFF, 16'h0001);
    rchk(8'h6F, 8'h20, "update bias only");
    n = imp_count;
    u_host.wr(8'h6F, 8'h03, ack);
    check("push count", 8'(n + 1), 8'(imp_count));
    check("push bits", 8'h03, {6'h00, imp_last});
    legacy = 1'b1;
    u_host.wr(8'h6F, 8'h02, ack);
    check("legacy no push", 8'(n + 1), 8'(imp_count));
    legacy = 1'b0;
    u_host.wait_clk(6);
    check("push on exit", 8'h02, {6'h00, imp_last});
    u_host.start();
    u_host.send_byte(8'hA0, ack);
    u_host.stop();
    check("other device nack", 8'h00, {7'h00, ack});
    trip = 1'b0;
    u_host.wait_clk(10);
    rchk(8'h70, 8'h76, "supply low forced");
    rchk(8'h6E, 8'h01, "status not ready");
    close_out();
  end
endmodule // monitor_status_alarm_regs_tb
